// ===== logic/lane_eq_override_regs.sv
// How it works
// - partner field holds bits 5:0 of last received lane-0 word
// - field writable only with training disabled
// - three 2-bit tap commands: inc, dec, hold
// - max-swing override replaces lane-0 preset limit
// - max-swing override also replaces preset main tap
// - bit 5 enables the max-swing override
// - min-swing override replaces lane-0 preset limit
// - bit 13 enables the min-swing override
// - post-tap override replaces lane-0 preset limit
// - bit 22 enables the post-tap override
// - pre-tap override value in bits 28:24
// - bit 29 enables the pre-tap override
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "lt_ovr_defs.svh"
module lane_eq_override_regs
  import lt_ovr_pkg::*;
#(
  parameter logic [4:0] MAX_SWING_PRESET  = 5'h1F,
  parameter logic [4:0] MIN_SWING_PRESET  = 5'h02,
  parameter logic [5:0] POST_TAP_PRESET   = 6'h3F,
  parameter logic [4:0] PRE_TAP_PRESET    = 5'h1F,
  parameter logic [4:0] MAIN_TAP_PRESET   = 5'h14
)
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // register port
  input  wire logic [7:0]   addr,
  input  wire logic [31:0]  wr_data,
  input  wire logic         wr_en,
  input  wire logic         rd_en,
  output      logic [31:0]  rd_data,
  // training control channel, lane 0
  input  wire logic         rx_word_valid,
  input  wire logic [15:0]  rx_word,
  // training state
  output      logic         training_enable,
  output      logic         lp_override_enable,
  output      logic [5:0]   partner_tap_update_word,
  output      logic         partner_word_new,
  // decoded partner commands
  output      tap_cmd_t     plus_tap_cmd,
  output      tap_cmd_t     main_tap_cmd,
  output      tap_cmd_t     minus_tap_cmd,
  output      logic         tap_cmd_rsvd,
  // effective lane-0 tx equalizer limits
  output      logic [4:0]   max_swing_limit,
  output      logic [4:0]   min_swing_limit_param,
  output      logic [5:0]   post_tap_limit,
  output      logic [4:0]   pre_tap_limit,
  output      logic [4:0]   preset_main_tap
);

  bank_st_t q;
  bank_st_t d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // register bank

  always_comb
  begin
    d          = q;
    d.word_new = 1'b0;
    // frame words only land while training runs
    if (q.train_en && rx_word_valid)
    begin
      d.partner  = rx_word[5:0];
      d.word_new = 1'b1;
    end
    if (wr_en)
    begin
      if (hit(addr, `LT_CTRL_OFS))
      begin
        d.train_en = wr_data[`LT_TRAIN_EN_BIT];
        d.ovr_en   = wr_data[`LT_OVR_EN_BIT];
      end
      // writes ignored while training owns the field
      if (hit(addr, `LT_PARTNER_OFS) && !q.train_en)
        d.partner = wr_data[`LT_PARTNER_MSB:`LT_PARTNER_LSB];
      // software word only acted on with override enabled
      if (hit(addr, `LT_NEWWORD_OFS) && wr_data[`LT_NEWWORD_BIT] && q.ovr_en && !q.train_en)
        d.word_new = 1'b1;
      if (hit(addr, `LT_LIMIT_OFS))
        d.limit_ovr = wr_data & `LT_LIMIT_MASK;
    end
    d.rd_data = `LT_RDATA_RST;
    if (rd_en)
    begin
      case (addr)
        `LT_CTRL_OFS:
        begin
          d.rd_data[`LT_TRAIN_EN_BIT] = q.train_en;
          d.rd_data[`LT_OVR_EN_BIT]   = q.ovr_en;
        end
        `LT_PARTNER_OFS: d.rd_data[`LT_PARTNER_MSB:`LT_PARTNER_LSB] = q.partner;
        `LT_LIMIT_OFS:   d.rd_data = q.limit_ovr;
        default:         d.rd_data = `LT_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q.train_en  <= `LT_TRAIN_EN_RST;
      q.ovr_en    <= `LT_OVR_EN_RST;
      q.partner   <= `LT_PARTNER_RST;
      q.limit_ovr <= `LT_LIMIT_RST;
      q.rd_data   <= `LT_RDATA_RST;
      q.word_new  <= 1'b0;
    end
    else
      q <= d;
  end

  assign rd_data                 = q.rd_data;
  assign training_enable         = q.train_en;
  assign lp_override_enable      = q.ovr_en;
  assign partner_tap_update_word = q.partner;
  assign partner_word_new        = q.word_new;

  ////////////////////////////////////////////////////////////////////////////
  // partner command decode

  tap_word_decode u_decode (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .word      (q.partner),
    .plus_cmd  (plus_tap_cmd),
    .main_cmd  (main_tap_cmd),
    .minus_cmd (minus_tap_cmd),
    .rsvd      (tap_cmd_rsvd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // limit selection, lane 0 only

  override_sel #(.W(5), .PRESET(MAX_SWING_PRESET)) u_max (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ovr_val (q.limit_ovr[`LT_MAXV_MSB:`LT_MAXV_LSB]),
    .ovr_en  (q.limit_ovr[`LT_MAXV_EN_BIT]),
    .lim     (max_swing_limit)
  );

  override_sel #(.W(5), .PRESET(MAIN_TAP_PRESET)) u_main (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ovr_val (q.limit_ovr[`LT_MAXV_MSB:`LT_MAXV_LSB]),
    .ovr_en  (q.limit_ovr[`LT_MAXV_EN_BIT]),
    .lim     (preset_main_tap)
  );

  override_sel #(.W(5), .PRESET(MIN_SWING_PRESET)) u_min (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ovr_val (q.limit_ovr[`LT_MINV_MSB:`LT_MINV_LSB]),
    .ovr_en  (q.limit_ovr[`LT_MINV_EN_BIT]),
    .lim     (min_swing_limit_param)
  );

  override_sel #(.W(6), .PRESET(POST_TAP_PRESET)) u_post (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ovr_val (q.limit_ovr[`LT_POST_MSB:`LT_POST_LSB]),
    .ovr_en  (q.limit_ovr[`LT_POST_EN_BIT]),
    .lim     (post_tap_limit)
  );

  override_sel #(.W(5), .PRESET(PRE_TAP_PRESET)) u_pre (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ovr_val (q.limit_ovr[`LT_PRE_MSB:`LT_PRE_LSB]),
    .ovr_en  (q.limit_ovr[`LT_PRE_EN_BIT]),
    .lim     (pre_tap_limit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  AST_PARTNER_CAPTURE:
    assert property (q.train_en && rx_word_valid |=> q.partner == $past(rx_word[5:0]))
    else $error("received word not captured");

  AST_PARTNER_RO:
    assert property (q.train_en && !rx_word_valid |=> $stable(q.partner))
    else $error("partner field changed while training");

  AST_PARTNER_WR:
    assert property (!q.train_en && wr_en && addr == `LT_PARTNER_OFS
                     |=> q.partner == $past(wr_data[`LT_PARTNER_MSB:`LT_PARTNER_LSB]))
    else $error("partner field write lost");

  AST_DECODE:
    assert property (q.train_en && rx_word_valid
                     |=> ##1 plus_tap_cmd == tap_cmd_t'($past(rx_word[5:4], 2))
                         && minus_tap_cmd == tap_cmd_t'($past(rx_word[1:0], 2)))
    else $error("tap command decode wrong");

  AST_NEW_WORD:
    assert property (!q.train_en && !q.ovr_en |=> !q.word_new)
    else $error("new word without override enable");

  AST_MAX_SEL:
    assert property (q.limit_ovr[`LT_MAXV_EN_BIT]
                     |=> max_swing_limit == $past(q.limit_ovr[`LT_MAXV_MSB:`LT_MAXV_LSB]))
    else $error("max swing override not applied");

  AST_MAX_PRESET:
    assert property (!q.limit_ovr[`LT_MAXV_EN_BIT] |=> max_swing_limit == MAX_SWING_PRESET
                     && preset_main_tap == MAIN_TAP_PRESET)
    else $error("max swing preset not used");

  AST_MAIN_TAP:
    assert property (q.limit_ovr[`LT_MAXV_EN_BIT] |=> preset_main_tap == max_swing_limit)
    else $error("main tap not overridden");

  AST_MIN_SEL:
    assert property (q.limit_ovr[`LT_MINV_EN_BIT]
                     |=> min_swing_limit_param == $past(q.limit_ovr[`LT_MINV_MSB:`LT_MINV_LSB]))
    else $error("min swing override not applied");

  AST_POST_SEL:
    assert property (q.limit_ovr[`LT_POST_EN_BIT]
                     |=> post_tap_limit == $past(q.limit_ovr[`LT_POST_MSB:`LT_POST_LSB]))
    else $error("post tap override not applied");

  AST_PRE_SEL:
    assert property (q.limit_ovr[`LT_PRE_EN_BIT]
                     |=> pre_tap_limit == $past(q.limit_ovr[`LT_PRE_MSB:`LT_PRE_LSB]))
    else $error("pre tap override not applied");

  AST_RESET_ZERO:
    assert property ($rose(rstn) |-> q.limit_ovr == `LT_LIMIT_RST)
    else $error("override register not zero after reset");

  AST_LIMIT_WRITE:
    assert property (wr_en && addr == `LT_LIMIT_OFS
                     |=> q.limit_ovr == ($past(wr_data) & `LT_LIMIT_MASK))
    else $error("limit override write wrong");

  AST_LIMIT_READ:
    assert property (rd_en && addr == `LT_LIMIT_OFS
                     |=> rd_data == $past(q.limit_ovr))
    else $error("limit override read back wrong");

  AST_PARTNER_READ:
    assert property (rd_en && addr == `LT_PARTNER_OFS
                     |=> rd_data == {10'h000, $past(q.partner), 16'h0000})
    else $error("partner field read back wrong");

  AST_CTRL_READ:
    assert property (rd_en && addr == `LT_CTRL_OFS
                     |=> rd_data[`LT_TRAIN_EN_BIT] == $past(q.train_en) && rd_data[`LT_OVR_EN_BIT] == $past(q.ovr_en))
    else $error("training control read back wrong");

  AST_RD_IDLE:
    assert property (!rd_en |=> rd_data == `LT_RDATA_RST)
    else $error("read data not cleared");

  AST_SW_NEW_WORD:
    assert property (wr_en && addr == `LT_NEWWORD_OFS && wr_data[`LT_NEWWORD_BIT] && q.ovr_en && !q.train_en
                     |=> partner_word_new)
    else $error("software new word not signalled");

  AST_RX_NEW_WORD:
    assert property (q.train_en && rx_word_valid |=> partner_word_new)
    else $error("received word not signalled");

  AST_MIN_PRESET:
    assert property (!q.limit_ovr[`LT_MINV_EN_BIT] |=> min_swing_limit_param == MIN_SWING_PRESET)
    else $error("min swing preset not used");

  AST_POST_PRESET:
    assert property (!q.limit_ovr[`LT_POST_EN_BIT] |=> post_tap_limit == POST_TAP_PRESET)
    else $error("post tap preset not used");

  AST_PRE_PRESET:
    assert property (!q.limit_ovr[`LT_PRE_EN_BIT] |=> pre_tap_limit == PRE_TAP_PRESET)
    else $error("pre tap preset not used");

  AST_MAIN_DECODE:
    assert property (q.train_en && rx_word_valid
                     |=> ##1 main_tap_cmd == tap_cmd_t'($past(rx_word[3:2], 2)))
    else $error("main tap command decode wrong");

  AST_RSVD_FLAG:
    assert property (1'b1
                     |=> tap_cmd_rsvd == ($past(&q.partner[5:4]) || $past(&q.partner[3:2]) || $past(&q.partner[1:0])))
    else $error("reserved command flag wrong");

endmodule : lane_eq_override_regs

// ===== logic/lt_ovr_defs.svh
`ifndef LT_OVR_DEFS_SVH
`define LT_OVR_DEFS_SVH

// register offsets on the plain register port
`define LT_CTRL_OFS      8'hD0
`define LT_NEWWORD_OFS   8'hD2
`define LT_PARTNER_OFS   8'hD5
`define LT_LIMIT_OFS     8'hD6

// training control fields
`define LT_TRAIN_EN_BIT  0
`define LT_OVR_EN_BIT    17
`define LT_NEWWORD_BIT   8

// partner update field
`define LT_PARTNER_MSB   21
`define LT_PARTNER_LSB   16

// update word sub-fields
`define LT_PLUS_MSB      5
`define LT_PLUS_LSB      4
`define LT_MAIN_MSB      3
`define LT_MAIN_LSB      2
`define LT_MINUS_MSB     1
`define LT_MINUS_LSB     0

// limit override fields
`define LT_MAXV_MSB      4
`define LT_MAXV_LSB      0
`define LT_MAXV_EN_BIT   5
`define LT_MINV_MSB      12
`define LT_MINV_LSB      8
`define LT_MINV_EN_BIT   13
`define LT_POST_MSB      21
`define LT_POST_LSB      16
`define LT_POST_EN_BIT   22
`define LT_PRE_MSB       28
`define LT_PRE_LSB       24
`define LT_PRE_EN_BIT    29
`define LT_LIMIT_MASK    32'h3F7F3F3F

// reset values
`define LT_TRAIN_EN_RST  1'b1
`define LT_OVR_EN_RST    1'b0
`define LT_PARTNER_RST   6'h00
`define LT_LIMIT_RST     32'h00000000
`define LT_RDATA_RST     32'h00000000

`endif

// ===== logic/lt_ovr_pkg.sv
package lt_ovr_pkg;

  typedef enum logic [1:0] {
    TAP_HOLD = 2'h0,
    TAP_INC  = 2'h1,
    TAP_DEC  = 2'h2,
    TAP_RSVD = 2'h3
  } tap_cmd_t;

  typedef struct packed {
    logic        train_en;
    logic        ovr_en;
    logic [5:0]  partner;
    logic [31:0] limit_ovr;
    logic [31:0] rd_data;
    logic        word_new;
  } bank_st_t;

  typedef struct packed {
    tap_cmd_t plus_cmd;
    tap_cmd_t main_cmd;
    tap_cmd_t minus_cmd;
    logic     rsvd;
  } dec_st_t;

endpackage : lt_ovr_pkg

// ===== logic/override_sel.sv
`timescale 1ns/1ps
module override_sel
  import lt_ovr_pkg::*;
#(
  parameter int unsigned           W      = 5,
  parameter logic [W-1:0]          PRESET = '0
)
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // override
  input  wire logic [W-1:0]  ovr_val,
  input  wire logic          ovr_en,
  // selected limit
  output      logic [W-1:0]  lim
);

  typedef struct packed {
    logic [W-1:0] lim;
  } sel_st_t;

  sel_st_t q;
  sel_st_t d;

  always_comb
  begin
    d     = q;
    d.lim = ovr_en ? ovr_val : PRESET;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      q.lim <= PRESET;
    else
      q <= d;
  end

  assign lim = q.lim;

endmodule : override_sel

// ===== logic/tap_word_decode.sv
`timescale 1ns/1ps
`include "lt_ovr_defs.svh"
module tap_word_decode
  import lt_ovr_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // update word
  input  wire logic [5:0]  word,
  // decoded commands
  output      tap_cmd_t    plus_cmd,
  output      tap_cmd_t    main_cmd,
  output      tap_cmd_t    minus_cmd,
  output      logic        rsvd
);

  dec_st_t q;
  dec_st_t d;

  function automatic tap_cmd_t to_cmd(input logic [1:0] f);
    to_cmd = tap_cmd_t'(f);
  endfunction : to_cmd

  always_comb
  begin
    d           = q;
    d.plus_cmd  = to_cmd(word[`LT_PLUS_MSB:`LT_PLUS_LSB]);
    d.main_cmd  = to_cmd(word[`LT_MAIN_MSB:`LT_MAIN_LSB]);
    d.minus_cmd = to_cmd(word[`LT_MINUS_MSB:`LT_MINUS_LSB]);
    d.rsvd      = (d.plus_cmd == TAP_RSVD) || (d.main_cmd == TAP_RSVD) || (d.minus_cmd == TAP_RSVD);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      q <= '{plus_cmd: TAP_HOLD, main_cmd: TAP_HOLD, minus_cmd: TAP_HOLD, rsvd: 1'b0};
    else
      q <= d;
  end

  assign plus_cmd  = q.plus_cmd;
  assign main_cmd  = q.main_cmd;
  assign minus_cmd = q.minus_cmd;
  assign rsvd      = q.rsvd;

endmodule : tap_word_decode

// ===== tb/lane_eq_override_regs_test.sv
`timescale 1ns/1ps
`include "lt_ovr_defs.svh"
module lane_eq_override_regs_test
  import lt_ovr_pkg::*;
;
  localparam logic [4:0] P_MAX  = 5'h1A;
  localparam logic [4:0] P_MIN  = 5'h03;
  localparam logic [5:0] P_POST = 6'h2E;
  localparam logic [4:0] P_PRE  = 5'h11;
  localparam logic [4:0] P_MAIN = 5'h12;
  logic        sys_clk, rstn, wr_en, rd_en, rx_word_valid;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, m_lim, d;
  logic [15:0] rx_word;
  logic        training_enable, lp_override_enable, partner_word_new, tap_cmd_rsvd;
  logic [5:0]  partner_tap_update_word, post_tap_limit, m_part;
  tap_cmd_t    plus_tap_cmd, main_tap_cmd, minus_tap_cmd;
  logic [4:0]  max_swing_limit, min_swing_limit_param, pre_tap_limit, preset_main_tap;
  int          miscompares, check_count, seed, i;
  logic [5:0]  part_q[$];

  lane_eq_override_regs #(.MAX_SWING_PRESET(P_MAX), .MIN_SWING_PRESET(P_MIN), .POST_TAP_PRESET(P_POST),
    .PRE_TAP_PRESET(P_PRE), .MAIN_TAP_PRESET(P_MAIN)) DUT (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .training_enable(training_enable), .lp_override_enable(lp_override_enable),
    .partner_tap_update_word(partner_tap_update_word), .partner_word_new(partner_word_new),
    .plus_tap_cmd(plus_tap_cmd), .main_tap_cmd(main_tap_cmd), .minus_tap_cmd(minus_tap_cmd),
    .tap_cmd_rsvd(tap_cmd_rsvd), .max_swing_limit(max_swing_limit),
    .min_swing_limit_param(min_swing_limit_param), .post_tap_limit(post_tap_limit),
    .pre_tap_limit(pre_tap_limit), .preset_main_tap(preset_main_tap));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("miscompares=%0d check_count=%0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask : rd

  // limit write, then effective limits one cycle after the register
  task automatic lim_wr(input logic [31:0] v);
    wr(`LT_LIMIT_OFS, v);
    m_lim = v & `LT_LIMIT_MASK;
    @(posedge sys_clk);
    #1;
    chk({27'h0, max_swing_limit}, {27'h0, m_lim[5] ? m_lim[4:0] : P_MAX});
    chk({27'h0, preset_main_tap}, {27'h0, m_lim[5] ? m_lim[4:0] : P_MAIN});
    chk({27'h0, min_swing_limit_param}, {27'h0, m_lim[13] ? m_lim[12:8] : P_MIN});
    chk({26'h0, post_tap_limit}, {26'h0, m_lim[22] ? m_lim[21:16] : P_POST});
    chk({27'h0, pre_tap_limit}, {27'h0, m_lim[29] ? m_lim[28:24] : P_PRE});
    rd(`LT_LIMIT_OFS, m_lim);
  endtask : lim_wr

  // one received word; taken only while training is enabled
  task automatic rx(input logic [15:0] w, input logic take);
    logic [5:0] f;
    f = w[5:0];
    @(posedge sys_clk);
    rx_word_valid <= 1'b1;
    rx_word       <= w;
    @(posedge sys_clk);
    rx_word_valid <= 1'b0;
    #1;
    if (take)
      part_q.push_back(f);
    if (part_q.size() > 0)
      m_part = part_q.pop_front();
    chk({26'h0, partner_tap_update_word}, {26'h0, m_part});
    chk({31'h0, partner_word_new}, {31'h0, take});
    @(posedge sys_clk);
    #1;
    chk({31'h0, partner_word_new}, 32'h0);
    if (take)
    begin
      chk({30'h0, plus_tap_cmd}, {30'h0, f[5:4]});
      chk({30'h0, main_tap_cmd}, {30'h0, f[3:2]});
      chk({30'h0, minus_tap_cmd}, {30'h0, f[1:0]});
      chk({31'h0, tap_cmd_rsvd}, {31'h0, (&f[5:4]) | (&f[3:2]) | (&f[1:0])});
    end
  endtask : rx

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    {rstn, wr_en, rd_en, rx_word_valid, addr, wr_data, rx_word} = '0;
    miscompares = 0;
    check_count = 0;
    seed = 15028;
    m_lim = '0;
    m_part = '0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk({31'h0, training_enable}, 32'h1);
    chk({31'h0, lp_override_enable}, 32'h0);
    rd(`LT_LIMIT_OFS, 32'h0);
    rd(8'h40, 32'h0);
    lim_wr(32'h00000025);
    d = {2'b11, 1'b1, P_PRE + 5'h2, 1'b1, 1'b1, P_POST + 6'h1, 2'b11, 1'b1, P_MIN + 5'h1, 2'b11, 1'b1, P_MAIN + 5'h1};
    lim_wr(d);
    for (i = 0; i < 8; i++)
    begin
      d = $random(seed);
      lim_wr(d);
    end
    wr(8'h41, 32'hFFFFFFFF);
    rd(`LT_LIMIT_OFS, m_lim);
    for (i = 0; i < 64; i++)
    begin
      d = $random(seed);
      rx({d[15:6], i[5:0]}, 1'b1);
    end
    wr(`LT_PARTNER_OFS, {10'h0, ~m_part, 16'h0});
    rd(`LT_PARTNER_OFS, {10'h0, m_part, 16'h0});
    wr(`LT_CTRL_OFS, 32'h0);
    #1;
    chk({31'h0, training_enable}, 32'h0);
    rx(16'h0015, 1'b0);
    m_part = 6'h2D;
    wr(`LT_PARTNER_OFS, {10'h0, m_part, 16'h0});
    rd(`LT_PARTNER_OFS, {10'h0, m_part, 16'h0});
    chk({26'h0, partner_tap_update_word}, {26'h0, m_part});
    wr(`LT_NEWWORD_OFS, 32'h00000100);
    #1;
    chk({31'h0, partner_word_new}, 32'h0);
    wr(`LT_CTRL_OFS, 32'h00020000);
    #1;
    chk({31'h0, lp_override_enable}, 32'h1);
    wr(`LT_NEWWORD_OFS, 32'h00000100);
    #1;
    chk({31'h0, partner_word_new}, 32'h1);
    @(posedge sys_clk);
    #1;
    chk({31'h0, partner_word_new}, 32'h0);
    wr(`LT_CTRL_OFS, 32'h00000001);
    wr(`LT_PARTNER_OFS, 32'h00150000);
    rd(`LT_PARTNER_OFS, {10'h0, m_part, 16'h0});
    lim_wr(32'h3F7F3F3F);
    @(posedge sys_clk);
    rstn <= 1'b0;
    #1;
    chk({27'h0, max_swing_limit}, {27'h0, P_MAX});
    chk({26'h0, post_tap_limit}, {26'h0, P_POST});
    chk({31'h0, training_enable}, 32'h1);
    @(posedge sys_clk);
    rstn <= 1'b1;
    rd(`LT_LIMIT_OFS, 32'h0);
    chk({27'h0, pre_tap_limit}, {27'h0, P_PRE});
    end_of_test();
  end
endmodule : lane_eq_override_regs_test
